// file: include/hrd_pkg.sv
// package for the harmonic ratio detect stage
// assumes a 10 MHz mclk and a measurement tick from the phasor front end
package hrd_pkg;
  localparam int          HRD_MAG_W         = 16;
  localparam int          HRD_PCT_W         = 7;
  localparam logic [6:0]  HRD_PCT_MIN       = 7'h0A;   // 10 %
  localparam logic [6:0]  HRD_PCT_MAX       = 7'h64;   // 100 %
  localparam logic [6:0]  HRD_PCT_RST       = 7'h0F;   // reset threshold
  localparam int          HRD_DLY_W         = 15;      // units of 10 ms
  localparam logic [14:0] HRD_DLY_MIN       = 15'h0003; // 0.03 s
  localparam logic [14:0] HRD_DLY_MAX       = 15'h7530; // 300.00 s
  localparam int          HRD_DLY_STEP_MS   = 10;
  localparam int          HRD_CLK_KHZ       = 10000;
  localparam int          HRD_STEP_CYC      = HRD_DLY_STEP_MS * HRD_CLK_KHZ;
  localparam int          HRD_PRE_W         = 17;
  localparam int          HRD_MIN_AMP_PCT   = 2;
  localparam int          HRD_BLOCKED_MS    = 60;
  typedef enum logic [2:0] {
    HRD_IDLE    = 3'b001,
    HRD_STARTED = 3'b010,
    HRD_TRIPPED = 3'b100
  } hrd_state_t;
endpackage

// file: include/hrd_phase_if.sv
// per-phase comparison results carried from the ratio comparators
// assumes one synchronous clock domain
`timescale 1ns/1ps
interface hrd_phase_if;
  logic [2:0] over;
  modport src (output over);
  modport dst (input over);
endinterface : hrd_phase_if

// file: logic/hrd_ratio_cmp.sv
// one-phase harmonic-to-fundamental ratio comparator
// assumes magnitudes are registered by the caller on a measurement tick
`timescale 1ns/1ps
module hrd_ratio_cmp
  import hrd_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 tick,
  input  wire logic [HRD_MAG_W-1:0] harm_mag,
  input  wire logic [HRD_MAG_W-1:0] fund_mag,
  input  wire logic [HRD_MAG_W-1:0] min_amp,
  input  wire logic [HRD_PCT_W-1:0] thr_pct,
  output      logic                 over
);
  // cross-multiplied so no divider is needed: harm*100 > fund*pct
  logic [HRD_MAG_W+6:0] lhs;
  logic [HRD_MAG_W+6:0] rhs;
  assign lhs = {harm_mag, 7'h00} - {2'h0, harm_mag, 5'h00} + {5'h00, harm_mag, 2'h0};
  assign rhs = (HRD_MAG_W+7)'(fund_mag) * (HRD_MAG_W+7)'(thr_pct);

  always_ff @(posedge mclk) begin
    if (rst) begin
      over <= 1'b0;
    end else if (tick) begin
      over <= (lhs > rhs) && (harm_mag >= min_amp);
    end
  end

  AST_RATIO_CMP: assert property (@(posedge mclk) disable iff (rst)
    !rst && tick |=> over == $past((32'(harm_mag) * 32'h64 > 32'(fund_mag) * 32'(thr_pct))
                                   && harm_mag >= min_amp)) else $error("ratio compare wrong");
  AST_HOLD_NO_TICK: assert property (@(posedge mclk) disable iff (rst)
    !rst && !tick |=> $stable(over)) else $error("compare changed without tick");
endmodule // hrd_ratio_cmp

// file: logic/hrd_stage.sv
// harmonic ratio detect stage (2nd: inrush, 5th: overexcitation)
// assumes harmonic and fundamental magnitudes per phase, updated on tick
`timescale 1ns/1ps
module hrd_stage
  import hrd_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   tick,
  input  wire logic                   fifth_sel,
  input  wire logic [3*HRD_MAG_W-1:0] harm_mag,
  input  wire logic [3*HRD_MAG_W-1:0] fund_mag,
  input  wire logic [HRD_MAG_W-1:0]   ct_nom_mag,
  input  wire logic [HRD_PCT_W-1:0]   thr_pct,
  input  wire logic [HRD_DLY_W-1:0]   op_delay,
  output      logic                   start_out,
  output      logic                   trip_out,
  output      logic                   blk_start,
  output      logic                   blk_trip
);
  hrd_phase_if ph ();
  hrd_state_t           state_reg;
  logic [HRD_PCT_W-1:0] thr_reg;
  logic [HRD_DLY_W-1:0] dly_reg;
  logic [HRD_PRE_W-1:0] pre_reg;
  logic [HRD_DLY_W-1:0] cnt_reg;
  logic [HRD_MAG_W-1:0] min_amp;
  logic                 any_over;

  // 2 % of CT nominal for the 2nd harmonic (zero when fifth_sel), approximated as nominal/64 + nominal/256 (about 1.95 %)
  assign min_amp = fifth_sel ? '0 : (ct_nom_mag >> 6) + (ct_nom_mag >> 8);

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ph
      hrd_ratio_cmp u_cmp (
        .mclk     (mclk),
        .rst      (rst),
        .tick     (tick),
        .harm_mag (harm_mag[g*HRD_MAG_W +: HRD_MAG_W]),
        .fund_mag (fund_mag[g*HRD_MAG_W +: HRD_MAG_W]),
        .min_amp  (min_amp),
        .thr_pct  (thr_reg),
        .over     (ph.over[g])
      );
    end
  endgenerate

  assign any_over = |ph.over;

  // settings clamped into legal range
  always_ff @(posedge mclk) begin
    if (rst) begin
      thr_reg <= HRD_PCT_RST;
    end else if (thr_pct < HRD_PCT_MIN) begin
      thr_reg <= HRD_PCT_MIN;
    end else if (thr_pct > HRD_PCT_MAX) begin
      thr_reg <= HRD_PCT_MAX;
    end else begin
      thr_reg <= thr_pct;
    end
  end

  AST_THR_RANGE: assert property (@(posedge mclk) disable iff (rst)
    thr_reg >= HRD_PCT_MIN && thr_reg <= HRD_PCT_MAX) else $error("threshold out of range");
  AST_THR_FOLLOW: assert property (@(posedge mclk) disable iff (rst)
    !rst && thr_pct >= HRD_PCT_MIN && thr_pct <= HRD_PCT_MAX |=> thr_reg == $past(thr_pct))
    else $error("threshold not taken");
  AST_THR_CLAMP_LO: assert property (@(posedge mclk) disable iff (rst)
    !rst && thr_pct < HRD_PCT_MIN |=> thr_reg == HRD_PCT_MIN) else $error("threshold low clamp");
  AST_THR_CLAMP_HI: assert property (@(posedge mclk) disable iff (rst)
    !rst && thr_pct > HRD_PCT_MAX |=> thr_reg == HRD_PCT_MAX) else $error("threshold high clamp");

  always_ff @(posedge mclk) begin
    if (rst) begin
      dly_reg <= HRD_DLY_MIN;
    end else if (op_delay < HRD_DLY_MIN) begin
      dly_reg <= HRD_DLY_MIN;
    end else if (op_delay > HRD_DLY_MAX) begin
      dly_reg <= HRD_DLY_MAX;
    end else begin
      dly_reg <= op_delay;
    end
  end

  AST_DLY_RANGE: assert property (@(posedge mclk) disable iff (rst)
    dly_reg >= HRD_DLY_MIN && dly_reg <= HRD_DLY_MAX) else $error("delay out of range");
  AST_DLY_FOLLOW: assert property (@(posedge mclk) disable iff (rst)
    !rst && op_delay >= HRD_DLY_MIN && op_delay <= HRD_DLY_MAX |=> dly_reg == $past(op_delay))
    else $error("delay not taken");
  AST_DLY_CLAMP_LO: assert property (@(posedge mclk) disable iff (rst)
    !rst && op_delay < HRD_DLY_MIN |=> dly_reg == HRD_DLY_MIN) else $error("delay low clamp");
  AST_DLY_CLAMP_HI: assert property (@(posedge mclk) disable iff (rst)
    !rst && op_delay > HRD_DLY_MAX |=> dly_reg == HRD_DLY_MAX) else $error("delay high clamp");

  // 10 ms prescaler only runs while started, so each count is a full step
  always_ff @(posedge mclk) begin
    if (rst || state_reg != HRD_STARTED || pre_reg == HRD_PRE_W'(HRD_STEP_CYC - 1)) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  AST_PRE_IDLE: assert property (@(posedge mclk) disable iff (rst)
    state_reg != HRD_STARTED |=> pre_reg == '0) else $error("prescaler ran outside started");
  AST_PRE_BOUND: assert property (@(posedge mclk) disable iff (rst)
    pre_reg <= HRD_PRE_W'(HRD_STEP_CYC - 1)) else $error("prescaler beyond step");

  always_ff @(posedge mclk) begin
    if (rst || !any_over) begin
      cnt_reg <= '0;
    end else if (state_reg == HRD_STARTED && pre_reg == HRD_PRE_W'(HRD_STEP_CYC - 1)) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  AST_CNT_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    !any_over |=> cnt_reg == '0) else $error("counter not cleared");
  AST_PRE_STEP: assert property (@(posedge mclk) disable iff (rst)
    $changed(cnt_reg) && cnt_reg != '0 |-> $past(pre_reg) == HRD_PRE_W'(HRD_STEP_CYC - 1))
    else $error("count step wrong");
  AST_CNT_STEP_ONE: assert property (@(posedge mclk) disable iff (rst)
    $changed(cnt_reg) && cnt_reg != '0 |-> cnt_reg == $past(cnt_reg) + 1'b1) else $error("count skipped");
  AST_CNT_BOUND: assert property (@(posedge mclk) disable iff (rst)
    cnt_reg <= HRD_DLY_MAX) else $error("count beyond delay range");
  AST_IDLE_CNT_ZERO: assert property (@(posedge mclk) disable iff (rst)
    state_reg == HRD_IDLE |-> cnt_reg == '0) else $error("count left in idle");

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= HRD_IDLE;
    end else begin
      unique case (state_reg)
        HRD_IDLE: begin
          if (any_over) begin
            state_reg <= HRD_STARTED;
          end
        end
        HRD_STARTED: begin
          if (!any_over) begin
            state_reg <= HRD_IDLE;
          end else if (cnt_reg >= dly_reg) begin
            state_reg <= HRD_TRIPPED;
          end
        end
        HRD_TRIPPED: begin
          if (!any_over) begin
            state_reg <= HRD_IDLE;
          end
        end
        default: state_reg <= HRD_IDLE;
      endcase
    end
  end

  // a delay lowered below the running count trips on the next edge
  AST_STATE_ONEHOT: assert property (@(posedge mclk) disable iff (rst)
    $onehot(state_reg)) else $error("state not one-hot");
  AST_ENTER_STARTED: assert property (@(posedge mclk) disable iff (rst)
    state_reg == HRD_IDLE && any_over |=> state_reg == HRD_STARTED) else $error("start state missed");
  AST_IDLE_NO_TRIP: assert property (@(posedge mclk) disable iff (rst)
    state_reg == HRD_IDLE |=> state_reg != HRD_TRIPPED) else $error("trip skipped the delay");
  AST_TRIP_ENTRY: assert property (@(posedge mclk) disable iff (rst)
    state_reg == HRD_STARTED && any_over && cnt_reg >= dly_reg |=> trip_out)
    else $error("trip missing after delay");
  AST_TRIP_AFTER_DELAY: assert property (@(posedge mclk) disable iff (rst)
    $rose(trip_out) |-> $past(cnt_reg) >= $past(dly_reg)) else $error("trip early");
  AST_TRIP_HOLD: assert property (@(posedge mclk) disable iff (rst)
    trip_out && any_over |=> trip_out) else $error("trip dropped while over");
  AST_TRIP_DROP: assert property (@(posedge mclk) disable iff (rst)
    trip_out && !any_over |=> state_reg == HRD_IDLE) else $error("trip not released");

  // start tracks the comparators only; no delay term enters it
  always_ff @(posedge mclk) begin
    if (rst) begin
      start_out <= 1'b0;
    end else begin
      start_out <= any_over;
    end
  end

  assign trip_out = (state_reg == HRD_TRIPPED);
  // downstream stages must use a delay above 60 ms to see these in time
  assign blk_start = start_out;
  assign blk_trip  = trip_out;

  AST_START_FOLLOWS: assert property (@(posedge mclk) disable iff (rst)
    any_over |=> start_out) else $error("start missing after over");
  AST_NO_START_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    !any_over |=> !start_out && !trip_out) else $error("start or trip held");
  AST_TRIP_NEEDS_START: assert property (@(posedge mclk) disable iff (rst)
    trip_out |-> start_out) else $error("trip without start");
  AST_BLK_MATCH: assert property (@(posedge mclk) disable iff (rst)
    blk_start == start_out && blk_trip == trip_out) else $error("blocking mismatch");
  AST_START_NO_DELAY: assert property (@(posedge mclk) disable iff (rst)
    $rose(any_over) |=> start_out && !trip_out) else $error("start delayed");
  AST_STARTED_START: assert property (@(posedge mclk) disable iff (rst)
    state_reg == HRD_STARTED |-> start_out) else $error("started without start");
  AST_START_RISE_IDLE: assert property (@(posedge mclk) disable iff (rst)
    $rose(start_out) |-> $past(state_reg) == HRD_IDLE) else $error("start rose outside idle");

  COV_START: cover property (@(posedge mclk) disable iff (rst) $rose(start_out));
  COV_TRIP: cover property (@(posedge mclk) disable iff (rst) $rose(trip_out));
  COV_DROP: cover property (@(posedge mclk) disable iff (rst) start_out ##1 !start_out);
  COV_FIFTH_TRIP: cover property (@(posedge mclk) disable iff (rst) fifth_sel && $rose(trip_out));
  COV_SECOND_START: cover property (@(posedge mclk) disable iff (rst) !fifth_sel && $rose(start_out));
endmodule // hrd_stage

// file: dv/hrd_front_model.sv
// front-end model: holds per-phase magnitudes and pulses the tick
// assumes the bench asks for one sample with smp_req high for one cycle
`timescale 1ns/1ps
module hrd_front_model
  import hrd_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   smp_req,
  input  wire logic [3*HRD_MAG_W-1:0] harm_in,
  input  wire logic [3*HRD_MAG_W-1:0] fund_in,
  output      logic                   tick,
  output      logic [3*HRD_MAG_W-1:0] harm_mag,
  output      logic [3*HRD_MAG_W-1:0] fund_mag
);
  // magnitudes launch with the tick, so a phase's pair always lands together
  always_ff @(posedge mclk) begin
    tick     <= smp_req;
    harm_mag <= harm_in;
    fund_mag <= fund_in;
  end
endmodule // hrd_front_model

// file: dv/test_harmonic_ratio_detect_stage.sv
// self-checking bench for the harmonic ratio detect stage
// assumes a fixed 100000-cycle delay step, so trip is only bounded, not reached
`timescale 1ns/1ps
module test_harmonic_ratio_detect_stage
  import hrd_pkg::*;
;
  logic        mclk = 0, rst = 1, smp_req = 0, fifth_sel = 0, tick, start_out, trip_out, blk_start, blk_trip, tr;
  logic [47:0] harm_in = 0, fund_in = 0, harm_mag, fund_mag, hv, fv;
  logic [15:0] ct_nom_mag = 16'h03E8;
  logic [6:0]  thr_pct = 7'h0F, thr;
  logic [14:0] op_delay = 15'h0003;
  int          seed = 32'hF968, failures = 0, n_compared = 0, cycles = 0, t;

  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  hrd_front_model FE (.mclk(mclk), .smp_req(smp_req), .harm_in(harm_in), .fund_in(fund_in), .tick(tick),
                      .harm_mag(harm_mag), .fund_mag(fund_mag));
  hrd_stage DUT (.mclk(mclk), .rst(rst), .tick(tick), .fifth_sel(fifth_sel), .harm_mag(harm_mag),
                 .fund_mag(fund_mag), .ct_nom_mag(ct_nom_mag), .thr_pct(thr_pct), .op_delay(op_delay),
                 .start_out(start_out), .trip_out(trip_out), .blk_start(blk_start), .blk_trip(blk_trip));

  task automatic chk(input string what, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask

  function automatic int clp(input int x);
    return x < 10 ? 10 : (x > 100 ? 100 : x);
  endfunction

  // strict compare; the amplitude gate only applies to the second variant
  function automatic logic exp_over(input int h, input int f, input int t, input int nom, input logic fs);
    return (h * 100 > t * f) && (fs || h >= nom / 64 + nom / 256);
  endfunction

  task automatic run(input logic [47:0] h, input logic [47:0] f, input logic [6:0] th, input logic fs,
                     input logic [15:0] nom);
    logic e;
    e = 1'b0;
    for (int p = 0; p < 3; p++) e |= exp_over(h[16*p+:16], f[16*p+:16], clp(th), nom, fs);
    @(posedge mclk);
    harm_in <= h;
    fund_in <= f;
    thr_pct <= th;
    fifth_sel <= fs;
    ct_nom_mag <= nom;
    op_delay <= $random(seed);
    smp_req <= 1'b1;
    @(posedge mclk);
    smp_req <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    chk("start_out", e, start_out);
    chk("blk_start", start_out, blk_start);
    chk("trip_out", 1'b0, trip_out);
    chk("blk_trip", trip_out, blk_trip);
  endtask

  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("start after reset", 1'b0, start_out);
    $display("test reset done");
    for (int i = 0; i < 60; i++) begin
      thr = $random(seed);
      t = clp(thr);
      for (int p = 0; p < 3; p++) begin
        fv[16*p+:16] = 1000 + ($random(seed) & 16'h7FFF);
        hv[16*p+:16] = t * fv[16*p+:16] / 100 + ($random(seed) & 1);
      end
      run(hv, fv, thr, $random(seed), $random(seed));
    end
    $display("test random ratios done");
    run({3{16'h01F4}}, {3{16'h03E8}}, 7'h0A, 1'b0, 16'hFFFF);
    run({3{16'h01F4}}, {3{16'h03E8}}, 7'h0A, 1'b1, 16'hFFFF);
    tr = 1'b0;
    // min delay is 300k cycles, so trip must stay low and start steady here
    repeat (1500) begin
      @(posedge mclk);
      #1;
      tr |= trip_out | ~start_out;
    end
    chk("trip before delay", 1'b0, tr);
    $display("test gate and hold done");
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    #1;
    chk("start in mid reset", 1'b0, start_out);
    @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("start after mid reset", 1'b0, start_out);
    chk("trip after mid reset", 1'b0, trip_out);
    run({3{16'h01F4}}, {3{16'h03E8}}, 7'h0A, 1'b1, 16'hFFFF);
    $display("test mid reset done");
    summarize();
  end
endmodule // test_harmonic_ratio_detect_stage
